// ===== hdl/led_sel_if.sv
// Carrier between the register bank and one LED source multiplexer
`timescale 1ns/1ps
interface led_sel_if;
  logic [3:0]  sel;
  logic [15:0] srcLevel;
  logic        led;
  modport drv (output sel, output srcLevel, input led);
  modport mux (input sel, input srcLevel, output led);
endinterface

// ===== hdl/led_source_mux.sv
// Picks one LED pin level from the selector code
`timescale 1ns/1ps
`include "phy_shadow_defs.svh"
module led_source_mux (
  led_sel_if.mux port
);
  always_comb begin
    case (port.sel)
      `LED_RESERVED: port.led = 1'b1;
      `LED_OFF:      port.led = 1'b1;
      `LED_ON:       port.led = 1'b0;
      default:       port.led = port.srcLevel[port.sel];
    endcase
  end
endmodule

// ===== hdl/phy_shadow_defs.svh
// Constants for the shadowed LED and auto power-down register bank
`ifndef PHY_SHADOW_DEFS_SVH
`define PHY_SHADOW_DEFS_SVH
`define ADDR_SHADOW       8'h38
`define ADDR_STATUS       8'h3C
`define ADDR_HI           7
`define WR_EN_BIT         15
`define SEL_HI            14
`define SEL_LO            10
`define SEL_RESET         5'h00
`define SEL_SPARE         5'h04
`define SEL_APD           5'h0A
`define SEL_LED           5'h0E
`define RETRY_HI          4
`define RETRY_LO          2
`define RETRY_LIMIT       3'h3
`define ROUTE_BIT         1
`define APD_EN_BIT        5
`define SLEEP_SEL_BIT     4
`define WAKE_HI           3
`define WAKE_LO           0
`define WAKE_RESET        4'h1
`define UPPER_HI          7
`define UPPER_LO          4
`define LOWER_HI          3
`define LOWER_LO          0
`define UPPER_RESET       4'h6
`define LOWER_RESET       4'h3
`define LED_RESERVED      4'hC
`define LED_OFF           4'hE
`define LED_ON            4'hF
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`define CLK_PERIOD_NS     25
`define NS_PER_MS         1000000
`define SLEEP_SHORT_MS    13'd2700
`define SLEEP_LONG_MS     13'd5400
`define WAKE_STEP_MS      13'd84
`define WAKE_WINDOW_MS    13'd1
`endif

// ===== hdl/phy_shadow_led_powerdown_regs.sv
// Shadowed spare, auto power-down and LED selector registers behind an AXI4-Lite slave
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "phy_shadow_defs.svh"
// Notes on behaviour
// - A write with bit 15 set updates bits 9 to 0 of the selected shadow, with bit 15 clear it only selects.
// - Selector 00100 addresses the spare control register with retry limit and energy-detect routing.
// - Selector 01010 addresses the auto power-down register with enable, sleep and wake-up timers.
// - Selector 01110 addresses the LED selector register holding two 4-bit source selectors.
// - Bits 4 to 2 of the spare register read the fixed downgrade retry limit, code plus two, default 011.
// - Spare bit 1 set routes energy detect onto the interrupt output, clear keeps the normal interrupt.
// - Auto power-down bit 5 enables the mode and resets to zero.
// - Auto power-down bit 4 picks a 5.4 s sleep timer when set, 2.7 s when clear, reset zero.
// - Auto power-down bits 3 to 0 set the wake-up interval in 84 ms steps, reset 0001.
// - Each LED selector maps codes 0000 to 1011 to their sources, 1110 to off high and 1111 to on low.
// - Code 1101 gives carrier sense in SGMII mode only, 1100 is reserved, upper is bits 7:4, lower 3:0.
module phy_shadow_led_powerdown_regs #(
  parameter int unsigned TICK_CYC = `NS_PER_MS / `CLK_PERIOD_NS
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [1:0]  linkSpeedInd,
  input  wire logic        transmitInd,
  input  wire logic        activityInd,
  input  wire logic        fullDuplexInd,
  input  wire logic        slaveInd,
  input  wire logic        intrRequest,
  input  wire logic        linkIndA,
  input  wire logic        receiveInd,
  input  wire logic        speedDowngradeInd,
  input  wire logic [2:1]  multiColourInd,
  input  wire logic        cableFaultInd,
  input  wire logic        carrierSense,
  input  wire logic        sgmiiMode,
  input  wire logic        energyDetect,
  output logic             interruptOut,
  output logic             upperLed,
  output logic             lowerLed,
  output logic             lowPower
);
  logic [4:0]                shadowSel_ff;
  logic                      energyRoute_ff;
  logic                      apdEnable_ff;
  logic                      sleepLong_ff;
  logic [3:0]                wakeSel_ff;
  logic [3:0]                upperLedSrc_ff;
  logic [3:0]                lowerLedSrc_ff;
  logic                      awready_ff;
  logic                      wready_ff;
  logic                      bvalid_ff;
  logic [1:0]                bresp_ff;
  logic                      arready_ff;
  logic                      rvalid_ff;
  logic [1:0]                rresp_ff;
  logic [31:0]               rdata_ff;
  logic                      interruptOut_ff;
  logic                      upperLed_ff;
  logic                      lowerLed_ff;
  logic                      lowPower_ff;
  phy_shadow_pkg::apd_state_t apdState_ff;
  logic [31:0]               tickCnt_ff;
  logic                      tick_ff;
  logic [12:0]               msCnt_ff;
  logic                      wrFire;
  logic                      wrShadow;
  logic                      rdFire;
  logic [15:0]               wordIn;
  logic [15:0]               shadowRead;
  logic [12:0]               sleepLimit;
  logic [12:0]               wakeLimit;
  logic [15:0]               srcCommon;
  led_sel_if                 upperPort ();
  led_sel_if                 lowerPort ();

  // Write channel: take address and data together, answer one cycle later
  assign wrFire   = awready_ff && wready_ff;
  assign wordIn   = s_axi_wdata[15:0];
  assign wrShadow = wrFire && (s_axi_awaddr[`ADDR_HI:2] == `ADDR_SHADOW >> 2) && (s_axi_wstrb[1:0] == 2'h3);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `RESP_OKAY;
    end else begin
      awready_ff <= s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff;
      wready_ff  <= s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff;
      if (wrFire) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= (s_axi_awaddr[`ADDR_HI:2] == `ADDR_SHADOW >> 2) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Selector follows every full write to the shared address
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shadowSel_ff <= `SEL_RESET;
    end else if (wrShadow) begin
      shadowSel_ff <= wordIn[`SEL_HI:`SEL_LO];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      energyRoute_ff <= 1'b0;
    end else if (wrShadow && wordIn[`WR_EN_BIT] && wordIn[`SEL_HI:`SEL_LO] == `SEL_SPARE) begin
      energyRoute_ff <= wordIn[`ROUTE_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      apdEnable_ff <= 1'b0;
      sleepLong_ff <= 1'b0;
      wakeSel_ff   <= `WAKE_RESET;
    end else if (wrShadow && wordIn[`WR_EN_BIT] && wordIn[`SEL_HI:`SEL_LO] == `SEL_APD) begin
      apdEnable_ff <= wordIn[`APD_EN_BIT];
      sleepLong_ff <= wordIn[`SLEEP_SEL_BIT];
      wakeSel_ff   <= wordIn[`WAKE_HI:`WAKE_LO];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      upperLedSrc_ff <= `UPPER_RESET;
      lowerLedSrc_ff <= `LOWER_RESET;
    end else if (wrShadow && wordIn[`WR_EN_BIT] && wordIn[`SEL_HI:`SEL_LO] == `SEL_LED) begin
      upperLedSrc_ff <= wordIn[`UPPER_HI:`UPPER_LO];
      lowerLedSrc_ff <= wordIn[`LOWER_HI:`LOWER_LO];
    end
  end

  // Read image of the selected shadow; reserved bits read as zero
  always_comb begin
    shadowRead                    = 16'h0000;
    shadowRead[`SEL_HI:`SEL_LO]   = shadowSel_ff;
    case (shadowSel_ff)
      `SEL_SPARE: begin
        shadowRead[`RETRY_HI:`RETRY_LO] = `RETRY_LIMIT;
        shadowRead[`ROUTE_BIT]          = energyRoute_ff;
      end
      `SEL_APD: begin
        shadowRead[`APD_EN_BIT]         = apdEnable_ff;
        shadowRead[`SLEEP_SEL_BIT]      = sleepLong_ff;
        shadowRead[`WAKE_HI:`WAKE_LO]   = wakeSel_ff;
      end
      `SEL_LED: begin
        shadowRead[`UPPER_HI:`UPPER_LO] = upperLedSrc_ff;
        shadowRead[`LOWER_HI:`LOWER_LO] = lowerLedSrc_ff;
      end
      default: begin
        shadowRead[`SEL_HI:`SEL_LO]     = shadowSel_ff;
      end
    endcase
  end

  // Read channel
  assign rdFire = arready_ff && s_axi_arvalid;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= `RESP_OKAY;
      rdata_ff   <= 32'h00000000;
    end else begin
      arready_ff <= s_axi_arvalid && !arready_ff && !rvalid_ff;
      if (rdFire) begin
        rvalid_ff <= 1'b1;
        if (s_axi_araddr[`ADDR_HI:2] == `ADDR_SHADOW >> 2) begin
          rdata_ff <= {16'h0000, shadowRead};
          rresp_ff <= `RESP_OKAY;
        end else if (s_axi_araddr[`ADDR_HI:2] == `ADDR_STATUS >> 2) begin
          rdata_ff <= {29'h00000000, lowPower_ff, apdState_ff};
          rresp_ff <= `RESP_OKAY;
        end else begin
          rdata_ff <= 32'h00000000;
          rresp_ff <= `RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // Interrupt pin function or routed energy detect
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      interruptOut_ff <= 1'b0;
    end else begin
      interruptOut_ff <= energyRoute_ff ? energyDetect : intrRequest;
    end
  end

  // LED sources as pin levels: an active indication pulls the pin low
  assign srcCommon = ~{2'b00, carrierSense && sgmiiMode, 1'b0, cableFaultInd, 1'b0, speedDowngradeInd,
                       receiveInd, linkIndA, interruptOut_ff, slaveInd, fullDuplexInd, activityInd,
                       transmitInd, linkSpeedInd};
  assign upperPort.sel      = upperLedSrc_ff;
  assign upperPort.srcLevel = {srcCommon[15:11], ~multiColourInd[2], srcCommon[9:0]};
  assign lowerPort.sel      = lowerLedSrc_ff;
  assign lowerPort.srcLevel = {srcCommon[15:11], ~multiColourInd[1], srcCommon[9:0]};

  led_source_mux upperMux (
    .port (upperPort.mux)
  );
  led_source_mux lowerMux (
    .port (lowerPort.mux)
  );

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      upperLed_ff <= 1'b1;
      lowerLed_ff <= 1'b1;
    end else begin
      upperLed_ff <= upperPort.led;
      lowerLed_ff <= lowerPort.led;
    end
  end

  // Millisecond enable pulse for the power-down timers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tickCnt_ff <= 32'h00000000;
      tick_ff    <= 1'b0;
    end else if (tickCnt_ff >= TICK_CYC - 1) begin
      tickCnt_ff <= 32'h00000000;
      tick_ff    <= 1'b1;
    end else begin
      tickCnt_ff <= tickCnt_ff + 32'h00000001;
      tick_ff    <= 1'b0;
    end
  end

  assign sleepLimit = sleepLong_ff ? `SLEEP_LONG_MS : `SLEEP_SHORT_MS;
  assign wakeLimit  = (wakeSel_ff == 4'h0) ? `WAKE_STEP_MS : 13'(`WAKE_STEP_MS * wakeSel_ff);

  // Auto power-down sequencer
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      apdState_ff <= phy_shadow_pkg::APD_RUN;
      msCnt_ff    <= 13'h0000;
      lowPower_ff <= 1'b0;
    end else if (!apdEnable_ff || (energyDetect && apdState_ff != phy_shadow_pkg::APD_SLEEP)) begin
      apdState_ff <= phy_shadow_pkg::APD_RUN;
      msCnt_ff    <= 13'h0000;
      lowPower_ff <= 1'b0;
    end else begin
      case (apdState_ff)
        phy_shadow_pkg::APD_RUN: begin
          apdState_ff <= phy_shadow_pkg::APD_COUNT;
          msCnt_ff    <= 13'h0000;
        end
        phy_shadow_pkg::APD_COUNT: begin
          if (tick_ff && msCnt_ff >= sleepLimit - 13'h0001) begin
            apdState_ff <= phy_shadow_pkg::APD_SLEEP;
            msCnt_ff    <= 13'h0000;
            lowPower_ff <= 1'b1;
          end else if (tick_ff) begin
            msCnt_ff <= msCnt_ff + 13'h0001;
          end
        end
        phy_shadow_pkg::APD_SLEEP: begin
          if (tick_ff && msCnt_ff >= wakeLimit - 13'h0001) begin
            apdState_ff <= phy_shadow_pkg::APD_WAKE;
            msCnt_ff    <= 13'h0000;
            lowPower_ff <= 1'b0;
          end else if (tick_ff) begin
            msCnt_ff <= msCnt_ff + 13'h0001;
          end
        end
        phy_shadow_pkg::APD_WAKE: begin
          if (tick_ff && msCnt_ff >= `WAKE_WINDOW_MS - 13'h0001) begin
            apdState_ff <= phy_shadow_pkg::APD_SLEEP;
            msCnt_ff    <= 13'h0000;
            lowPower_ff <= 1'b1;
          end else if (tick_ff) begin
            msCnt_ff <= msCnt_ff + 13'h0001;
          end
        end
        default: begin
          apdState_ff <= phy_shadow_pkg::APD_RUN;
        end
      endcase
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;
  assign interruptOut  = interruptOut_ff;
  assign upperLed      = upperLed_ff;
  assign lowerLed      = lowerLed_ff;
  assign lowPower      = lowPower_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  spare_write_a: assert property ((wrShadow && wordIn[`WR_EN_BIT] && wordIn[`SEL_HI:`SEL_LO] == `SEL_SPARE)
    |=> energyRoute_ff == $past(wordIn[`ROUTE_BIT])) else $error("spare write not stored");
  select_only_a: assert property ((wrShadow && !wordIn[`WR_EN_BIT]) |=> $stable(energyRoute_ff)
    && $stable(apdEnable_ff) && $stable(upperLedSrc_ff)) else $error("select write changed data");
  retry_read_a: assert property ((rdFire && shadowSel_ff == `SEL_SPARE && s_axi_araddr == `ADDR_SHADOW)
    |=> rdata_ff[`RETRY_HI:`RETRY_LO] == `RETRY_LIMIT) else $error("retry limit wrong");
  apd_write_a: assert property ((wrShadow && wordIn[`WR_EN_BIT] && wordIn[`SEL_HI:`SEL_LO] == `SEL_APD)
    |=> apdEnable_ff == $past(wordIn[`APD_EN_BIT]) && wakeSel_ff == $past(wordIn[`WAKE_HI:`WAKE_LO]))
    else $error("power-down write not stored");
  led_write_a: assert property ((wrShadow && wordIn[`WR_EN_BIT] && wordIn[`SEL_HI:`SEL_LO] == `SEL_LED)
    |=> upperLedSrc_ff == $past(wordIn[`UPPER_HI:`UPPER_LO])) else $error("upper selector not stored");
  other_keep_a: assert property ((wrShadow && wordIn[`SEL_HI:`SEL_LO] == `SEL_SPARE)
    |=> $stable(upperLedSrc_ff) && $stable(apdEnable_ff)) else $error("other shadow disturbed");
  irq_route_a: assert property (##1 interruptOut_ff == ($past(energyRoute_ff) ? $past(energyDetect)
    : $past(intrRequest))) else $error("interrupt output source wrong");
  forced_led_a: assert property (lowerLedSrc_ff == `LED_ON ##1 lowerLedSrc_ff == `LED_ON
    |-> lowerLed_ff == 1'b0) else $error("forced-on LED not low");
  sleep_entry_a: assert property ($rose(lowPower_ff) |-> $past(apdEnable_ff) && !$past(energyDetect))
    else $error("sleep entered without cause");
  disable_wake_a: assert property (!apdEnable_ff |=> !lowPower_ff) else $error("low power while disabled");

  sleep_seen_c: cover property ($rose(lowPower_ff));
  route_seen_c: cover property (energyRoute_ff && energyDetect ##1 interruptOut_ff);
  shadow_read_c: cover property (rdFire && shadowSel_ff == `SEL_LED);
endmodule

// ===== hdl/phy_shadow_pkg.sv
// Types shared by the shadow register bank
package phy_shadow_pkg;
  typedef enum logic [1:0] {
    APD_RUN   = 2'b00,
    APD_COUNT = 2'b01,
    APD_SLEEP = 2'b10,
    APD_WAKE  = 2'b11
  } apd_state_t;
endpackage

// ===== verification/test_phy_shadow_led_powerdown_regs.sv
// Self-checking bench for the shadowed LED and auto power-down register bank
`timescale 1ns/1ps
`include "phy_shadow_defs.svh"
module test_phy_shadow_led_powerdown_regs;
  localparam int unsigned TICK = 4;
  logic        clock;
  logic        rst_b;
  logic [7:0]  s_axi_awaddr;
  logic [7:0]  s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [31:0] s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [13:0] src;
  logic        sgmiiMode, energyDetect, interruptOut, upperLed, lowerLed, lowPower;
  logic [1:0]  resp;
  logic [31:0] word;
  int          failures;
  int          total_checks;
  int          cyc;

  phy_shadow_led_powerdown_regs #(.TICK_CYC(TICK)) dut (
    .clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .linkSpeedInd(src[1:0]), .transmitInd(src[2]), .activityInd(src[3]), .fullDuplexInd(src[4]),
    .slaveInd(src[5]), .intrRequest(src[6]), .linkIndA(src[7]), .receiveInd(src[8]),
    .speedDowngradeInd(src[9]), .multiColourInd({src[10], src[10]}), .cableFaultInd(src[11]),
    .carrierSense(src[13]), .sgmiiMode, .energyDetect, .interruptOut, .upperLed, .lowerLed, .lowPower
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock) cyc <= cyc + 1;

  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic timed_out(input string what);
    failures++;
    $display("wrong value %s expected an answer seen none", what);
    complete_run();
  endtask

  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_resp(input string name, input logic [1:0] exp, input logic [1:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic check_pin(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask

  // Entered and left just after a rising edge; address and data are offered together
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int   n;
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clock);
      awDone = awDone | (s_axi_awready === 1'b1);
      wDone = wDone | (s_axi_wready === 1'b1);
      s_axi_awvalid <= !awDone;
      s_axi_wvalid <= !wDone;
      n++;
      if (n > 50) timed_out("write handshake");
    end
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (n > 50) timed_out("write response");
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (n > 50) timed_out("read handshake");
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (n > 50) timed_out("read data");
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Select a shadow with write enable clear, then read it back
  task automatic sel_read(input logic [4:0] sel, input logic [31:0] exp, input string name);
    logic [1:0]  r;
    logic [31:0] d;
    axi_write(`ADDR_SHADOW, {17'h00000, sel, 10'h000}, 4'hF, r);
    axi_read(`ADDR_SHADOW, d, r);
    check_word(name, exp, d);
  endtask

  // Both selectors get one code; only that code's source differs from the rest, except that codes 0 and 1 set both speed bits
  task automatic led_case(input logic [3:0] code, input logic v);
    logic [1:0]  r;
    logic [13:0] pat;
    logic        exp;
    pat = {14{~v}};
    pat[code] = v;
    if (code < 4'h2) pat[1:0] = {v, v};
    axi_write(`ADDR_SHADOW, {16'h0000, 8'hB8, code, code}, 4'hF, r);
    src <= pat;
    exp = (code == 4'hF) ? 1'b0 : ((code == 4'hC || code == 4'hE) ? 1'b1 : ~v);
    repeat (4) @(posedge clock);
    check_pin("upper led", exp, upperLed);
    check_pin("lower led", exp, lowerLed);
  endtask

  task automatic wait_power(input logic lvl);
    int n;
    n = 0;
    while (lowPower !== lvl) begin
      @(posedge clock);
      n++;
      if (n > 30000) timed_out("power state");
    end
  endtask

  // Energy is present on entry; it drops as the configuration lands
  task automatic power_run(input logic [31:0] cfg, input int sleepTicks, input int wakeTicks);
    int          t0;
    int          t1;
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(`ADDR_SHADOW, cfg, 4'hF, r);
    energyDetect <= 1'b0;
    t0 = cyc;
    wait_power(1'b1);
    t1 = cyc;
    check_pin("sleep time", 1'b1, (t1 - t0 >= sleepTicks * TICK - 2) && (t1 - t0 <= (sleepTicks + 1) * TICK + 8));
    axi_read(`ADDR_STATUS, d, r);
    check_word("status asleep", 32'h00000006, d);
    wait_power(1'b0);
    t0 = cyc;
    check_pin("wake time", 1'b1, (t0 - t1 >= wakeTicks * TICK - 2) && (t0 - t1 <= (wakeTicks + 1) * TICK + 4));
    energyDetect <= 1'b1;
    repeat (3 * TICK) @(posedge clock);
    axi_read(`ADDR_STATUS, d, r);
    check_word("status running", 32'h00000000, d);
  endtask

  task automatic end_test(input string name);
    $display("test %s done, checks %0d failures %0d", name, total_checks, failures);
  endtask

  initial begin
    failures = 0;
    total_checks = 0;
    cyc = 0;
    rst_b <= 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
    src <= 14'h0000;
    sgmiiMode <= 1'b1;
    energyDetect <= 1'b0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    sel_read(`SEL_SPARE, 32'h0000100C, "spare reset");
    sel_read(`SEL_APD, 32'h00002801, "power-down reset");
    sel_read(`SEL_LED, 32'h00003863, "led selector reset");
    sel_read(5'h1F, 32'h00007C00, "unnamed shadow");
    end_test("reset values");
    axi_write(`ADDR_SHADOW, 32'h0000A83F, 4'hF, resp);
    check_resp("shadow write", `RESP_OKAY, resp);
    axi_write(`ADDR_SHADOW, 32'h00002810, 4'hF, resp);
    sel_read(`SEL_APD, 32'h0000283F, "select only write");
    axi_write(`ADDR_SHADOW, 32'h0000901E, 4'hF, resp);
    sel_read(`SEL_SPARE, 32'h0000100E, "retry limit fixed");
    sel_read(`SEL_LED, 32'h00003863, "other shadow kept");
    axi_write(`ADDR_SHADOW, 32'h0000B8FF, 4'h1, resp);
    check_resp("partial strobe", `RESP_OKAY, resp);
    sel_read(`SEL_LED, 32'h00003863, "partial strobe ignored");
    axi_write(`ADDR_STATUS, 32'h00000000, 4'hF, resp);
    check_resp("read-only write", `RESP_SLVERR, resp);
    axi_read(8'h40, word, resp);
    check_resp("unmapped read", `RESP_SLVERR, resp);
    check_word("unmapped data", 32'h00000000, word);
    end_test("write enable");
    energyDetect <= 1'b1;
    repeat (3) @(posedge clock);
    check_pin("energy routed", 1'b1, interruptOut);
    axi_write(`ADDR_SHADOW, 32'h0000B86F, 4'hF, resp);
    repeat (4) @(posedge clock);
    check_pin("routed led", 1'b0, upperLed);
    axi_write(`ADDR_SHADOW, 32'h00009000, 4'hF, resp);
    repeat (3) @(posedge clock);
    check_pin("normal interrupt low", 1'b0, interruptOut);
    src <= 14'h0040;
    repeat (3) @(posedge clock);
    check_pin("normal interrupt high", 1'b1, interruptOut);
    end_test("energy routing");
    for (int v = 0; v < 2; v++) begin
      for (int c = 0; c < 16; c++) begin
        led_case(c[3:0], v[0]);
      end
    end
    axi_write(`ADDR_SHADOW, 32'h0000B8FE, 4'hF, resp);
    repeat (4) @(posedge clock);
    check_pin("upper field", 1'b0, upperLed);
    check_pin("lower field", 1'b1, lowerLed);
    axi_write(`ADDR_SHADOW, 32'h0000B8DD, 4'hF, resp);
    src <= 14'h3FFF;
    sgmiiMode <= 1'b0;
    repeat (4) @(posedge clock);
    check_pin("carrier outside sgmii", 1'b1, upperLed);
    end_test("led selectors");
    src <= 14'h0000;
    energyDetect <= 1'b1;
    power_run(32'h0000A821, 2700, 84);
    power_run(32'h0000A832, 5400, 168);
    end_test("auto power-down");
    complete_run();
  end
endmodule
